/* hdl/pfr_feature_pd.sv */
// feature control register with parallel/serial load and phase/frequency detector
// Summary of operation
// - parallel mode: data lines captured on rising feature write strobe
// - serial mode: bits shifted on shift-clock rise while strobe high, first to bit 7
// - serial bits reach active register only on strobe falling edge
// - each feature function active when its bit is one
// - power-down bit disables everything except the programming interface
// - counter-load bit forces continuous counter load
// - modulus-select bit drives modulus select onto test output
// - prescaler bit drives raw prescaler output onto test output while modulus-select bit is clear
// - phase detector reacts only to rising divided clock edges
// - divided VCO leading pulses pump-down low
// - divided reference leading pulses pump-up low
// - pump pulse width follows phase offset
// - lock filter node is NAND of both pump waveforms
// - open-drain lock detect equals AND of pump waveforms
// - feature bits act only while feature-enable input is low
`timescale 1ns/100ps
module pfr_feature_pd #(
   parameter int FEAT_W = pfr_pkg::FEAT_W
) (
   // clock and reset
   input  wire logic              mclk,
   input  wire logic              rst,
   // programming port pins
   input  wire logic              feat_enable_n,
   input  wire logic              serial_sel,
   input  wire logic              feat_wr,
   input  wire logic              serial_load,
   input  wire logic              shift_clk,
   input  wire logic              serial_data,
   input  wire logic [FEAT_W-1:0] par_data,
   // internal prescaler signals
   input  wire logic              modulus_select,
   input  wire logic              presc_raw,
   // divided clocks from counters
   input  wire logic              main_divided_clk,
   input  wire logic              ref_divided_clk,
   // controls to the core
   output logic                   core_pwr_down,
   output logic                   counter_load,
   output logic                   test_out,
   output logic                   main_div_out,
   output logic                   main_div_oe_n,
   output logic                   ref_div_out,
   output logic                   ref_div_oe_n,
   // phase detector and lock outputs
   output logic                   pump_up_n,
   output logic                   pump_down_n,
   output logic                   lock_filter,
   output logic                   lock_detect_out,
   output logic                   lock_detect_oe_n
);

   // two-flop synchronisers for all pins
   // sync1 and sync2 form the synchroniser proper; sync3 is a plain
   // history stage read only by the edge detectors below
   // latency: pin edge to feature register is three mclk cycles,
   // one more to the registered control outputs
   // pins are slow against mclk: every level must stand three cycles
   localparam int NS = 8;
   logic [NS-1:0]     sync1;
   logic [NS-1:0]     sync2;
   logic [NS-1:0]     sync3;
   logic [FEAT_W-1:0] pd_s1;
   logic [FEAT_W-1:0] pd_s2;
   logic [NS-1:0]     pins;
   // bit order of the pin vector, msb first
   assign pins = {feat_enable_n, serial_sel, feat_wr, serial_load, shift_clk,
                  serial_data, main_divided_clk, ref_divided_clk};

   always_ff @(posedge mclk) begin
      if (rst) begin
         sync1 <= '0;
         sync2 <= '0;
         sync3 <= '0;
         pd_s1 <= '0;
         pd_s2 <= '0;
      end else begin
         sync1 <= pins;
         sync2 <= sync1;
         sync3 <= sync2;
         pd_s1 <= par_data;
         pd_s2 <= pd_s1;
      end
   end

   // synchronised pin levels
   logic en_n_s, ser_s, wr_s, sload_s, sclk_s, sdat_s, main_s, ref_s;
   assign {en_n_s, ser_s, wr_s, sload_s, sclk_s, sdat_s, main_s, ref_s} = sync2;

   // one-cycle edge pulses from synchronised level and its history
   // sync3 starts at zero like the idle pins, so no false edge after reset
   logic wr_rise, wr_fall, sclk_rise, main_rise, ref_rise;
   assign wr_rise   = wr_s & ~sync3[5];
   assign wr_fall   = ~wr_s & sync3[5];
   assign sclk_rise = sclk_s & ~sync3[3];
   assign main_rise = main_s & ~sync3[1];
   assign ref_rise  = ref_s & ~sync3[0];

   // feature register: shift stage and active buffer
   // parallel loads go straight to the active buffer; serial loads fill
   // the shift stage and reach the buffer only when the strobe drops,
   // so the controls never show half-shifted bits
   logic [FEAT_W-1:0] shift_reg, next_shift_reg, feat_reg, next_feat_reg;

   always_comb begin
      next_shift_reg = shift_reg;
      next_feat_reg  = feat_reg;
      if (!ser_s) begin
         if (wr_rise)
            next_feat_reg = pd_s2;
      end else begin
         if (wr_s && !sload_s && sclk_rise)
            next_shift_reg = {shift_reg[FEAT_W-2:0], sdat_s};
         if (wr_fall)
            next_feat_reg = shift_reg;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         shift_reg <= pfr_pkg::FEAT_RESET;
         feat_reg  <= pfr_pkg::FEAT_RESET;
      end else begin
         shift_reg <= next_shift_reg;
         feat_reg  <= next_feat_reg;
      end
   end

   // decoded controls, gated by feature enable
   pfr_pkg::pfr_ctrl_s ctrl;
   always_comb begin
      ctrl = '0;
      if (!en_n_s) begin
         ctrl.pwr_down  = feat_reg[pfr_pkg::BIT_PWR_DOWN];
         ctrl.cnt_load  = feat_reg[pfr_pkg::BIT_CNT_LOAD];
         ctrl.mod_sel_out = feat_reg[pfr_pkg::BIT_MOD_SEL_OUT];
         ctrl.presc_out = feat_reg[pfr_pkg::BIT_PRESC_OUT];
         ctrl.out_dis   = feat_reg[pfr_pkg::BIT_OUT_DIS];
      end
   end

   // phase/frequency detector state
   // a rising edge sets its flag; when both flags would be set they clear
   // together, so coincident edges give no pulse and a pulse lasts exactly
   // from the leading edge to the lagging one
   logic up_st, dn_st, next_up_st, next_dn_st;
   always_comb begin
      next_up_st = up_st;
      next_dn_st = dn_st;
      if (ctrl.pwr_down) begin
         next_up_st = 1'b0;
         next_dn_st = 1'b0;
      end else begin
         if (ref_rise) next_up_st = 1'b1;
         if (main_rise) next_dn_st = 1'b1;
         if (next_up_st && next_dn_st) begin
            next_up_st = 1'b0;
            next_dn_st = 1'b0;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         up_st <= 1'b0;
         dn_st <= 1'b0;
      end else begin
         up_st <= next_up_st;
         dn_st <= next_dn_st;
      end
   end

   // test output source select, modulus select has priority
   logic next_test_out;
   always_comb begin
      next_test_out = 1'b0;
      if (!ctrl.pwr_down) begin
         if (ctrl.mod_sel_out)    next_test_out = modulus_select;
         else if (ctrl.presc_out) next_test_out = presc_raw;
      end
   end

   // registered outputs
   // power-down idles everything here but leaves the feature port alive
   // pump and lock outputs use the next detector state so all four agree
   always_ff @(posedge mclk) begin
      if (rst) begin
         core_pwr_down    <= 1'b0;
         counter_load     <= 1'b0;
         test_out         <= 1'b0;
         main_div_out     <= 1'b0;
         main_div_oe_n    <= 1'b1;
         ref_div_out      <= 1'b0;
         ref_div_oe_n     <= 1'b1;
         pump_up_n        <= 1'b1;
         pump_down_n      <= 1'b1;
         lock_filter      <= 1'b0;
         lock_detect_out  <= 1'b0;
         lock_detect_oe_n <= 1'b1;
      end else begin
         core_pwr_down    <= ctrl.pwr_down;
         counter_load     <= ctrl.cnt_load & ~ctrl.pwr_down;
         test_out         <= next_test_out;
         main_div_out     <= main_s & ~ctrl.pwr_down;
         main_div_oe_n    <= ctrl.out_dis | ctrl.pwr_down;
         ref_div_out      <= ref_s & ~ctrl.pwr_down;
         ref_div_oe_n     <= ctrl.out_dis | ctrl.pwr_down;
         pump_up_n        <= ~next_up_st;
         pump_down_n      <= ~next_dn_st;
         lock_filter      <= ~(~next_up_st & ~next_dn_st);
         lock_detect_out  <= 1'b0;
         // open drain: pulled low when lock node is high
         lock_detect_oe_n <= ~(next_up_st | next_dn_st);
      end
   end

endmodule

/* hdl/pfr_pkg.sv */
// shared constants and types for the feature register and phase detector
package pfr_pkg;
   // feature register layout (register bit index = parallel line number)
   localparam int FEAT_W         = 8;
   localparam int BIT_OUT_DIS    = 0;  // serial index 7
   localparam int BIT_PRESC_OUT  = 1;  // serial index 6
   localparam int BIT_MOD_SEL_OUT = 2; // serial index 5
   localparam int BIT_CNT_LOAD   = 3;  // serial index 4
   localparam int BIT_PWR_DOWN   = 4;  // serial index 3
   localparam logic [7:0] FEAT_RESET = 8'h00;
   localparam int SYNC_STAGES    = 2;

   // decoded feature controls
   typedef struct packed {
      logic pwr_down;
      logic cnt_load;
      logic mod_sel_out;
      logic presc_out;
      logic out_dis;
   } pfr_ctrl_s;
endpackage

/* bench/pfr_ctrl_model.sv */
// controller model driving the feature programming port
`timescale 1ns/100ps
module pfr_ctrl_model (
   // clock
   input  wire logic       mclk,
   // programming pins
   output logic            serial_sel, feat_wr, serial_load, shift_clk, serial_data,
   output logic [7:0]      par_data
);
   initial begin
      {serial_sel, feat_wr, serial_load, shift_clk, serial_data} = 5'h00;
      par_data = 8'h00;
   end
   // each pin level held a few cycles for the synchronisers
   task automatic hold(input int n);
      repeat (n) @(negedge mclk);
   endtask
   // parallel load, data stable around the strobe rise
   task automatic par_write(input logic [7:0] d);
      serial_sel = 1'b0;
      par_data = d & 8'h1F;
      hold(4);
      feat_wr = 1'b1;
      hold(4);
      feat_wr = 1'b0;
      par_data = ~par_data;
      hold(4);
   endtask
   // serial load, first bit sent lands in bit 7
   task automatic ser_write(input logic [7:0] d);
      logic [7:0] v;
      v = d & 8'h1F;
      serial_sel = 1'b1;
      hold(4);
      feat_wr = 1'b1;
      for (int i = 7; i >= 0; i--) begin
         serial_data = v[i];
         hold(3);
         shift_clk = 1'b1;
         hold(3);
         shift_clk = 1'b0;
      end
      serial_data = ~serial_data;
      hold(3);
      feat_wr = 1'b0;
      hold(6);
   endtask
endmodule

/* bench/pfr_feature_pd_assertions.sv */
// assertions on the feature controls and phase detector outputs
`timescale 1ns/100ps
module pfr_chk (
   input wire logic mclk, rst, feat_enable_n, modulus_select, presc_raw,
   input wire logic core_pwr_down, counter_load, test_out, main_div_oe_n, ref_div_oe_n,
   input wire logic pump_up_n, pump_down_n, lock_filter, lock_detect_out, lock_detect_oe_n,
   input wire logic main_divided_clk, ref_divided_clk, main_div_out, ref_div_out
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   // lock outputs follow the pump pair
   chk_lock_nand: assert property (lock_filter == !(pump_up_n && pump_down_n)) else $error("lock filter");
   chk_lock_and: assert property (lock_detect_oe_n == (pump_up_n && pump_down_n)) else $error("lock oe");
   chk_ld_low: assert property (lock_detect_out == 1'b0) else $error("lock level");
   chk_pump_excl: assert property (pump_up_n || pump_down_n) else $error("both pumps");
   // power-down idles pumps and clock pins
   chk_pd_idle: assert property (core_pwr_down [*3] |-> pump_up_n && pump_down_n) else $error("pd pump");
   chk_pd_oe: assert property (core_pwr_down [*3] |-> main_div_oe_n && ref_div_oe_n) else $error("pd oe");
   chk_enh_off: assert property (feat_enable_n [*8] |-> !(counter_load || core_pwr_down)) else $error("enh");
   chk_test_src: assert property (test_out |-> $past(modulus_select) || $past(presc_raw)) else $error("test");
   // divided clock pins follow the pins three cycles late unless powered down
   chk_main_follow: assert property (!core_pwr_down |-> main_div_out == $past(main_divided_clk, 3)) else $error("main div");
   chk_ref_follow: assert property (!core_pwr_down |-> ref_div_out == $past(ref_divided_clk, 3)) else $error("ref div");
endmodule
bind pfr_feature_pd pfr_chk u_chk (.mclk, .rst, .feat_enable_n, .modulus_select, .presc_raw, .core_pwr_down,
   .counter_load, .test_out, .main_div_oe_n, .ref_div_oe_n, .pump_up_n, .pump_down_n, .lock_filter,
   .lock_detect_out, .lock_detect_oe_n, .main_divided_clk, .ref_divided_clk, .main_div_out, .ref_div_out);

/* bench/testbench.sv */
// self-checking bench for the feature register and phase detector
`timescale 1ns/100ps
module testbench;
   logic mclk = 1'b0, rst = 1'b1, feat_enable_n = 1'b0, main_divided_clk = 1'b0, ref_divided_clk = 1'b0;
   logic modulus_select = 1'b0, presc_raw = 1'b1;
   wire logic serial_sel, feat_wr, serial_load, shift_clk, serial_data;
   wire logic [7:0] par_data;
   logic core_pwr_down, counter_load, test_out, main_div_out, main_div_oe_n, ref_div_out, ref_div_oe_n;
   logic pump_up_n, pump_down_n, lock_filter, lock_detect_out, lock_detect_oe_n;
   int n_errors = 0, n_tests = 0, nu, nd;
   // data beside power-down, counter load, test output, out-disable
   logic [11:0] rows [7] = '{12'h084, 12'h109, 12'h011, 12'h040, 12'h022, 12'h060, 12'h000};
   always #12.5 mclk = ~mclk;
   // pump low cycle counters
   always @(posedge mclk) begin
      nu += int'(!pump_up_n);
      nd += int'(!pump_down_n);
   end
   pfr_ctrl_model model (.mclk, .serial_sel, .feat_wr, .serial_load, .shift_clk, .serial_data, .par_data);
   pfr_feature_pd DUT (.mclk, .rst, .feat_enable_n, .serial_sel, .feat_wr, .serial_load, .shift_clk,
      .serial_data, .par_data, .modulus_select, .presc_raw, .main_divided_clk, .ref_divided_clk,
      .core_pwr_down, .counter_load, .test_out, .main_div_out, .main_div_oe_n, .ref_div_out, .ref_div_oe_n,
      .pump_up_n, .pump_down_n, .lock_filter, .lock_detect_out, .lock_detect_oe_n);
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_tests++;
      if (g !== e) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic complete_run;
      $display("errors %0d tests %0d", n_errors, n_tests);
      if (n_errors == 0 && n_tests > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // one clock leads the other by k cycles, then both fall apart
   task automatic pd_run(input logic ref_first, input int k);
      nu = 0;
      nd = 0;
      if (ref_first || k == 0) ref_divided_clk = 1'b1;
      if (!ref_first || k == 0) main_divided_clk = 1'b1;
      if (k > 0) begin
         repeat (k) @(negedge mclk);
         {ref_divided_clk, main_divided_clk} = 2'b11;
      end
      repeat (8) @(negedge mclk);
      ref_divided_clk = 1'b0;
      repeat (6) @(negedge mclk);
      main_divided_clk = 1'b0;
      repeat (6) @(negedge mclk);
      chk("pump up", ref_first ? 8'(k) : 8'h00, nu[7:0]);
      chk("pump down", ref_first ? 8'h00 : 8'(k), nd[7:0]);
   endtask
   initial begin
      repeat (8) @(negedge mclk);
      chk("reset", 8'h1E, {core_pwr_down, counter_load, test_out, main_div_oe_n, ref_div_oe_n,
         pump_up_n, pump_down_n, lock_filter});
      rst = 1'b0;
      repeat (4) @(negedge mclk);
      foreach (rows[i]) begin
         model.par_write(rows[i][11:4]);
         chk("controls", {3'h0, rows[i][3:0], rows[i][0]}, {3'h0, core_pwr_down, counter_load, test_out,
            main_div_oe_n, ref_div_oe_n});
      end
      fork
         model.ser_write(8'h08);
         begin
            repeat (40) @(negedge mclk);
            chk("mid shift", 8'h00, {4'h0, core_pwr_down, counter_load, test_out, main_div_oe_n});
         end
      join
      chk("serial", 8'h04, {4'h0, core_pwr_down, counter_load, test_out, main_div_oe_n});
      feat_enable_n = 1'b1;
      repeat (10) @(negedge mclk);
      chk("enable off", 8'h00, {7'h0, counter_load});
      feat_enable_n = 1'b0;
      repeat (10) @(negedge mclk);
      chk("enable on", 8'h01, {7'h0, counter_load});
      // modulus select reaches the test output only when its bit is set
      modulus_select = 1'b1;
      model.par_write(8'h04);
      chk("modulus select", 8'h01, {7'h0, test_out});
      model.par_write(8'h00);
      chk("modulus off", 8'h00, {7'h0, test_out});
      modulus_select = 1'b0;
      model.ser_write(8'h00);
      for (int k = 0; k < 8; k += 3) begin
         pd_run(1'b1, k);
         pd_run(1'b0, k);
      end
      complete_run();
   end
   // watchdog well beyond the expected run
   initial begin
      #200000;
      n_errors++;
      complete_run();
   end
endmodule
